// >>> rtl/cpu_core_register_set_defines.svh
// constants for the processor core register set
`ifndef CPU_CORE_REGISTER_SET_DEFINES_SVH
`define CPU_CORE_REGISTER_SET_DEFINES_SVH

// ==========================================================
// reset values
`define STACK_RESET_VALUE 16'h01FF
`define STACK_PAGE 8'h01
`define STACK_LOW_RESET 8'hFF
`define FLAGS_RESET_VALUE 8'hE8

// ==========================================================
// condition flag field positions
`define FLAG_CARRY_BIT 0
`define FLAG_ZERO_BIT 1
`define FLAG_NEG_BIT 2
`define FLAG_PRIO_LOW_BIT 3
`define FLAG_HALF_BIT 4
`define FLAG_PRIO_HIGH_BIT 5
`define FLAG_FIXED_ONES 2'h3

// ==========================================================
// interrupt priority pair encodings {high, low}
`define PRIO_LEVEL0 2'h2
`define PRIO_LEVEL1 2'h1
`define PRIO_LEVEL2 2'h0
`define PRIO_LEVEL3 2'h3

// ==========================================================
// stack bytes per sequence
`define CALL_STACK_BYTES 3'h2
`define IRQ_STACK_BYTES 3'h5
`define SINGLE_STACK_BYTES 3'h1

`endif

// >>> rtl/cpu_core_register_set_pkg.sv
// types shared by the processor core register set
package cpu_core_register_set_pkg;

    typedef enum logic [4:0] {
        CMD_NOP,
        CMD_PREFIX_Y,
        CMD_ALU,
        CMD_LOAD,
        CMD_STACK_LOW_WR,
        CMD_STACK_RESET,
        CMD_SET_CARRY,
        CMD_RESET_CARRY,
        CMD_BIT_TEST,
        CMD_IRQ_ENABLE,
        CMD_IRQ_DISABLE,
        CMD_HALT,
        CMD_WAIT_IRQ,
        CMD_JUMP,
        CMD_PC_ADVANCE,
        CMD_PUSH,
        CMD_POP,
        CMD_CALL,
        CMD_RETURN,
        CMD_IRQ_ENTRY,
        CMD_IRQ_RETURN
    } cmd_e;

    typedef enum logic [3:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR,
        ALU_XOR, ALU_SLL, ALU_SRL, ALU_RLC, ALU_RRC
    } alu_e;

    typedef enum logic [1:0] {REG_ACC, REG_INDEX, REG_FLAGS} reg_e;

    typedef enum logic [2:0] {
        BYTE_PC_LO, BYTE_PC_HI, BYTE_INDEX_X, BYTE_ACC, BYTE_FLAGS,
        BYTE_INDEX_Y
    } byte_e;

    typedef enum logic [2:0] {
        SEQ_PUSH, SEQ_POP, SEQ_CALL, SEQ_RETURN, SEQ_IRQ, SEQ_IRQ_RET
    } seq_e;

    typedef enum logic [1:0] {S_IDLE, S_XFER, S_DRAIN} state_e;

endpackage

// >>> rtl/cpu_core_register_set.sv
// programmer-visible register set of the 8-bit processor core
`timescale 1ns/1ns
`include "cpu_core_register_set_defines.svh"

module cpu_core_register_set (
    input wire logic clk, // core clock, 125 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic cmdValid, // command offered
    output logic cmdReady, // command taken when valid
    input wire cpu_core_register_set_pkg::cmd_e cmd, // command code
    input wire cpu_core_register_set_pkg::alu_e aluOp, // alu operation
    input wire cpu_core_register_set_pkg::reg_e regSel, // target reg
    input wire logic [7:0] operand, // data operand
    input wire logic [15:0] target, // jump, call or vector address
    input wire logic [1:0] irqPrio, // {high, low} of the irq priority
    output logic [7:0] accum, // accumulator
    output logic [7:0] indexX, // first index register
    output logic [7:0] indexY, // second index register
    output logic [15:0] programCounter, // program counter
    output logic [7:0] condFlags, // condition flags byte
    output logic [15:0] stackPointer, // stack pointer
    output logic [15:0] memAddr, // stack memory address
    output logic [7:0] memWrData, // stack write data
    output logic memWe, // stack write strobe
    output logic memRe, // stack read strobe
    input wire logic [7:0] memRdData // stack read data, same cycle
);

    // ======================================================
    // state
    cpu_core_register_set_pkg::state_e state;
    cpu_core_register_set_pkg::seq_e seq;
    cpu_core_register_set_pkg::byte_e oneByte;
    cpu_core_register_set_pkg::byte_e memSel;
    cpu_core_register_set_pkg::byte_e curByte;
    logic [2:0] step;
    logic [2:0] lastStep;
    logic [1:0] pendPrio;
    logic [15:0] pendTarget;
    logic useY;
    logic [7:0] stackLow;
    logic [7:0] pcLo;
    logic [7:0] pcHi;
    logic prioHigh;
    logic prioLow;
    logic halfCarry;
    logic negFlag;
    logic zeroFlag;
    logic carryFlag;
    logic accept;
    logic isPush;
    logic [7:0] aluA;
    logic [7:0] aluRes;
    logic aluCarry;
    logic aluHalf;
    logic [8:0] wide;
    logic [4:0] nib;
    logic arith;
    logic [7:0] accA;
    logic [7:0] idxX;
    logic [7:0] idxY;

    assign cmdReady = (state == cpu_core_register_set_pkg::S_IDLE);
    assign accept = cmdValid && cmdReady;
    assign accum = accA;
    assign indexX = idxX;
    assign indexY = idxY;
    assign programCounter = {pcHi, pcLo};
    assign stackPointer = {`STACK_PAGE, stackLow};
    assign condFlags = {`FLAG_FIXED_ONES, prioHigh, halfCarry, prioLow,
        negFlag, zeroFlag, carryFlag};

    // ======================================================
    // alu
    always_comb begin
        aluA = (regSel == cpu_core_register_set_pkg::REG_INDEX) ?
            (useY ? idxY : idxX) : accA;
        wide = 9'h000;
        nib = 5'h00;
        aluRes = 8'h00;
        aluCarry = carryFlag;
        aluHalf = halfCarry;
        arith = 1'b1;
        unique case (aluOp)
            cpu_core_register_set_pkg::ALU_ADD,
            cpu_core_register_set_pkg::ALU_ADC: begin
                wide = {1'b0, aluA} + {1'b0, operand} + {8'h00,
                    (aluOp == cpu_core_register_set_pkg::ALU_ADC) &
                    carryFlag};
                nib = {1'b0, aluA[3:0]} + {1'b0, operand[3:0]} + {4'h0,
                    (aluOp == cpu_core_register_set_pkg::ALU_ADC) &
                    carryFlag};
                aluHalf = nib[4];
                aluRes = wide[7:0];
                aluCarry = wide[8];
            end
            cpu_core_register_set_pkg::ALU_SUB,
            cpu_core_register_set_pkg::ALU_SBC: begin
                wide = {1'b0, aluA} - {1'b0, operand} - {8'h00,
                    (aluOp == cpu_core_register_set_pkg::ALU_SBC) &
                    carryFlag};
                aluRes = wide[7:0];
                aluCarry = wide[8]; // borrow
            end
            cpu_core_register_set_pkg::ALU_AND: begin
                aluRes = aluA & operand;
                arith = 1'b0;
            end
            cpu_core_register_set_pkg::ALU_OR: begin
                aluRes = aluA | operand;
                arith = 1'b0;
            end
            cpu_core_register_set_pkg::ALU_XOR: begin
                aluRes = aluA ^ operand;
                arith = 1'b0;
            end
            cpu_core_register_set_pkg::ALU_SLL: begin
                aluRes = {aluA[6:0], 1'b0};
                aluCarry = aluA[7];
            end
            cpu_core_register_set_pkg::ALU_SRL: begin
                aluRes = {1'b0, aluA[7:1]};
                aluCarry = aluA[0];
            end
            cpu_core_register_set_pkg::ALU_RLC: begin
                aluRes = {aluA[6:0], carryFlag};
                aluCarry = aluA[7];
            end
            cpu_core_register_set_pkg::ALU_RRC: begin
                aluRes = {carryFlag, aluA[7:1]};
                aluCarry = aluA[0];
            end
            default: begin
                arith = 1'b0;
            end
        endcase
    end

    // ======================================================
    // stack sequencer
    // the context never names the second index, so it survives entry
    // and return untouched
    always_comb begin
        curByte = oneByte;
        unique case (seq)
            cpu_core_register_set_pkg::SEQ_CALL:
                curByte = (step == 3'h0) ? cpu_core_register_set_pkg::BYTE_PC_LO
                    : cpu_core_register_set_pkg::BYTE_PC_HI;
            cpu_core_register_set_pkg::SEQ_RETURN:
                curByte = (step == 3'h0) ? cpu_core_register_set_pkg::BYTE_PC_HI
                    : cpu_core_register_set_pkg::BYTE_PC_LO;
            cpu_core_register_set_pkg::SEQ_IRQ,
            cpu_core_register_set_pkg::SEQ_IRQ_RET: begin
                unique case ((seq == cpu_core_register_set_pkg::SEQ_IRQ) ?
                    step : 3'h4 - step)
                    3'h0: curByte = cpu_core_register_set_pkg::BYTE_PC_LO;
                    3'h1: curByte = cpu_core_register_set_pkg::BYTE_PC_HI;
                    3'h2: curByte = cpu_core_register_set_pkg::BYTE_INDEX_X;
                    3'h3: curByte = cpu_core_register_set_pkg::BYTE_ACC;
                    default: curByte = cpu_core_register_set_pkg::BYTE_FLAGS;
                endcase
            end
            default: curByte = oneByte;
        endcase
    end

    assign isPush = (seq == cpu_core_register_set_pkg::SEQ_PUSH) ||
        (seq == cpu_core_register_set_pkg::SEQ_CALL) ||
        (seq == cpu_core_register_set_pkg::SEQ_IRQ);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= cpu_core_register_set_pkg::S_IDLE;
            seq <= cpu_core_register_set_pkg::SEQ_PUSH;
            oneByte <= cpu_core_register_set_pkg::BYTE_ACC;
            step <= 3'h0;
            lastStep <= 3'h0;
            pendPrio <= `PRIO_LEVEL3;
            pendTarget <= 16'h0000;
        end else begin
            unique case (state)
                cpu_core_register_set_pkg::S_IDLE: begin
                    step <= 3'h0;
                    pendPrio <= irqPrio;
                    pendTarget <= target;
                    oneByte <= (regSel == cpu_core_register_set_pkg::REG_ACC) ?
                        cpu_core_register_set_pkg::BYTE_ACC :
                        (regSel == cpu_core_register_set_pkg::REG_FLAGS) ?
                        cpu_core_register_set_pkg::BYTE_FLAGS :
                        useY ? cpu_core_register_set_pkg::BYTE_INDEX_Y :
                        cpu_core_register_set_pkg::BYTE_INDEX_X;
                    if (accept) begin
                        state <= cpu_core_register_set_pkg::S_XFER;
                        lastStep <= `SINGLE_STACK_BYTES - 3'h1;
                        unique case (cmd)
                            cpu_core_register_set_pkg::CMD_PUSH:
                                seq <= cpu_core_register_set_pkg::SEQ_PUSH;
                            cpu_core_register_set_pkg::CMD_POP:
                                seq <= cpu_core_register_set_pkg::SEQ_POP;
                            cpu_core_register_set_pkg::CMD_CALL: begin
                                seq <= cpu_core_register_set_pkg::SEQ_CALL;
                                lastStep <= `CALL_STACK_BYTES - 3'h1;
                            end
                            cpu_core_register_set_pkg::CMD_RETURN: begin
                                seq <= cpu_core_register_set_pkg::SEQ_RETURN;
                                lastStep <= `CALL_STACK_BYTES - 3'h1;
                            end
                            cpu_core_register_set_pkg::CMD_IRQ_ENTRY: begin
                                seq <= cpu_core_register_set_pkg::SEQ_IRQ;
                                lastStep <= `IRQ_STACK_BYTES - 3'h1;
                            end
                            cpu_core_register_set_pkg::CMD_IRQ_RETURN: begin
                                seq <= cpu_core_register_set_pkg::SEQ_IRQ_RET;
                                lastStep <= `IRQ_STACK_BYTES - 3'h1;
                            end
                            default: state <= cpu_core_register_set_pkg::S_IDLE;
                        endcase
                    end
                end
                cpu_core_register_set_pkg::S_XFER: begin
                    step <= step + 3'h1;
                    if (step == lastStep) begin
                        state <= cpu_core_register_set_pkg::S_DRAIN;
                    end
                end
                cpu_core_register_set_pkg::S_DRAIN: begin
                    state <= cpu_core_register_set_pkg::S_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // stack memory port, registered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            memWe <= 1'b0;
            memRe <= 1'b0;
            memAddr <= `STACK_RESET_VALUE;
            memWrData <= 8'h00;
            memSel <= cpu_core_register_set_pkg::BYTE_ACC;
        end else begin
            memWe <= (state == cpu_core_register_set_pkg::S_XFER) && isPush;
            memRe <= (state == cpu_core_register_set_pkg::S_XFER) && !isPush;
            memSel <= curByte;
            memAddr <= {`STACK_PAGE, isPush ? stackLow :
                stackLow + 8'h01};
            unique case (curByte)
                cpu_core_register_set_pkg::BYTE_PC_LO: memWrData <= pcLo;
                cpu_core_register_set_pkg::BYTE_PC_HI: memWrData <= pcHi;
                cpu_core_register_set_pkg::BYTE_INDEX_X: memWrData <= idxX;
                cpu_core_register_set_pkg::BYTE_INDEX_Y: memWrData <= idxY;
                cpu_core_register_set_pkg::BYTE_ACC: memWrData <= accA;
                default: memWrData <= condFlags;
            endcase
        end
    end

    // ======================================================
    // stack pointer: 8-bit arithmetic wraps silently inside the page
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stackLow <= `STACK_LOW_RESET;
        end else if (state == cpu_core_register_set_pkg::S_XFER) begin
            stackLow <= isPush ? stackLow - 8'h01 : stackLow + 8'h01;
        end else if (accept &&
            cmd == cpu_core_register_set_pkg::CMD_STACK_RESET) begin
            stackLow <= `STACK_LOW_RESET;
        end else if (accept &&
            cmd == cpu_core_register_set_pkg::CMD_STACK_LOW_WR) begin
            stackLow <= operand;
        end
    end

    // ======================================================
    // prefix selection lasts for exactly one following command
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            useY <= 1'b0;
        end else if (accept) begin
            useY <= (cmd == cpu_core_register_set_pkg::CMD_PREFIX_Y);
        end
    end

    // ======================================================
    // data registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accA <= 8'h00;
            idxX <= 8'h00;
            idxY <= 8'h00;
        end else if (memRe) begin
            if (memSel == cpu_core_register_set_pkg::BYTE_ACC) begin
                accA <= memRdData;
            end
            if (memSel == cpu_core_register_set_pkg::BYTE_INDEX_X) begin
                idxX <= memRdData;
            end
            if (memSel == cpu_core_register_set_pkg::BYTE_INDEX_Y) begin
                idxY <= memRdData;
            end
        end else if (accept && (cmd == cpu_core_register_set_pkg::CMD_ALU ||
            cmd == cpu_core_register_set_pkg::CMD_LOAD)) begin
            unique case (regSel)
                cpu_core_register_set_pkg::REG_INDEX: begin
                    if (useY) begin
                        idxY <= (cmd == cpu_core_register_set_pkg::CMD_ALU) ?
                            aluRes : operand;
                    end else begin
                        idxX <= (cmd == cpu_core_register_set_pkg::CMD_ALU) ?
                            aluRes : operand;
                    end
                end
                cpu_core_register_set_pkg::REG_ACC: begin
                    accA <= (cmd == cpu_core_register_set_pkg::CMD_ALU) ?
                        aluRes : operand;
                end
                default: begin
                end
            endcase
        end
    end

    // ======================================================
    // program counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pcLo <= 8'h00;
            pcHi <= 8'h00;
        end else if (memRe && memSel == cpu_core_register_set_pkg::BYTE_PC_LO) begin
            pcLo <= memRdData;
        end else if (memRe && memSel == cpu_core_register_set_pkg::BYTE_PC_HI) begin
            pcHi <= memRdData;
        end else if (state == cpu_core_register_set_pkg::S_DRAIN &&
            (seq == cpu_core_register_set_pkg::SEQ_CALL ||
            seq == cpu_core_register_set_pkg::SEQ_IRQ)) begin
            {pcHi, pcLo} <= pendTarget;
        end else if (accept && cmd == cpu_core_register_set_pkg::CMD_JUMP) begin
            {pcHi, pcLo} <= target;
        end else if (accept &&
            cmd == cpu_core_register_set_pkg::CMD_PC_ADVANCE) begin
            {pcHi, pcLo} <= {pcHi, pcLo} + {8'h00, operand};
        end
    end

    // ======================================================
    // condition flags, also stacked and restored through the stack memory port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {prioHigh, prioLow} <= `PRIO_LEVEL3;
            halfCarry <= 1'b0;
            negFlag <= 1'b0;
            zeroFlag <= 1'b0;
            carryFlag <= 1'b0;
        end else if (memRe && memSel == cpu_core_register_set_pkg::BYTE_FLAGS) begin
            prioHigh <= memRdData[`FLAG_PRIO_HIGH_BIT];
            prioLow <= memRdData[`FLAG_PRIO_LOW_BIT];
            halfCarry <= memRdData[`FLAG_HALF_BIT];
            negFlag <= memRdData[`FLAG_NEG_BIT];
            zeroFlag <= memRdData[`FLAG_ZERO_BIT];
            carryFlag <= memRdData[`FLAG_CARRY_BIT];
        end else if (state == cpu_core_register_set_pkg::S_DRAIN &&
            seq == cpu_core_register_set_pkg::SEQ_IRQ) begin
            {prioHigh, prioLow} <= pendPrio;
        end else if (accept) begin
            unique case (cmd)
                cpu_core_register_set_pkg::CMD_ALU: begin
                    negFlag <= aluRes[7];
                    zeroFlag <= (aluRes == 8'h00);
                    if (arith) begin
                        carryFlag <= aluCarry;
                    end
                    if (aluOp == cpu_core_register_set_pkg::ALU_ADD ||
                        aluOp == cpu_core_register_set_pkg::ALU_ADC) begin
                        halfCarry <= aluHalf;
                    end
                end
                cpu_core_register_set_pkg::CMD_LOAD: begin
                    if (regSel == cpu_core_register_set_pkg::REG_FLAGS) begin
                        prioHigh <= operand[`FLAG_PRIO_HIGH_BIT];
                        prioLow <= operand[`FLAG_PRIO_LOW_BIT];
                        halfCarry <= operand[`FLAG_HALF_BIT];
                        negFlag <= operand[`FLAG_NEG_BIT];
                        zeroFlag <= operand[`FLAG_ZERO_BIT];
                        carryFlag <= operand[`FLAG_CARRY_BIT];
                    end else begin
                        negFlag <= operand[7];
                        zeroFlag <= (operand == 8'h00);
                    end
                end
                cpu_core_register_set_pkg::CMD_SET_CARRY: carryFlag <= 1'b1;
                cpu_core_register_set_pkg::CMD_RESET_CARRY: carryFlag <= 1'b0;
                cpu_core_register_set_pkg::CMD_BIT_TEST: carryFlag <= operand[0];
                cpu_core_register_set_pkg::CMD_IRQ_ENABLE,
                cpu_core_register_set_pkg::CMD_HALT,
                cpu_core_register_set_pkg::CMD_WAIT_IRQ:
                    {prioHigh, prioLow} <= `PRIO_LEVEL0;
                cpu_core_register_set_pkg::CMD_IRQ_DISABLE:
                    {prioHigh, prioLow} <= `PRIO_LEVEL3;
                default: begin
                end
            endcase
        end
    end

endmodule

// >>> tb/cpu_stack_mem.sv
// stack memory model beside the register set
`timescale 1ns/1ns
module cpu_stack_mem (
    input wire logic clk, // core clock
    input wire logic [15:0] memAddr, // stack address
    input wire logic [7:0] memWrData, // byte to store
    input wire logic memWe, // write strobe
    input wire logic memRe, // read strobe
    output logic [7:0] memRdData // read byte, same cycle
);
    logic [7:0] mem [256];
    // inverse outside reads so stale data never passes for an answer
    assign memRdData = memRe ? mem[memAddr[7:0]] : ~mem[memAddr[7:0]];
    always @(posedge clk) begin
        if (memWe) begin
            mem[memAddr[7:0]] <= memWrData;
        end
    end
endmodule

// >>> tb/cpu_core_register_set_props.sv
// assertions on the ports of the processor core register set
`timescale 1ns/1ns
module cpu_core_register_set_props (
    input wire logic clk, // core clock
    input wire logic rst_n, // sync reset, low
    input wire logic cmdValid, // command offered
    input wire logic cmdReady, // command taken
    input wire cpu_core_register_set_pkg::cmd_e cmd, // command
    input wire logic [1:0] irqPrio, // irq priority
    input wire logic [7:0] indexY, // second index
    input wire logic [15:0] programCounter, // pc
    input wire logic [7:0] condFlags, // flags
    input wire logic [15:0] stackPointer, // stack pointer
    input wire logic [15:0] memAddr, // stack address
    input wire logic [7:0] memWrData, // stack data
    input wire logic memWe, // write strobe
    input wire logic memRe // read strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic irqGo;
    logic callGo;
    assign irqGo = cmdValid && cmdReady
        && cmd == cpu_core_register_set_pkg::CMD_IRQ_ENTRY;
    assign callGo = cmdValid && cmdReady
        && cmd == cpu_core_register_set_pkg::CMD_CALL;
    // ========
    // checks
    a_sp_page: assert property (stackPointer[15:8] == 8'h01)
        else $error("stack pointer left its page");
    a_flag_ones: assert property (condFlags[7:6] == 2'h3)
        else $error("fixed flag bits not one");
    a_push_addr: assert property (memWe |->
        memAddr == {8'h01, stackPointer[7:0] + 8'h01})
        else $error("push address not the free slot");
    a_pop_addr: assert property (memRe |-> memAddr == stackPointer)
        else $error("pop address wrong");
    a_irq_bytes: assert property (irqGo |-> ##2 memWe [*5] ##1 !memWe)
        else $error("irq entry byte count wrong");
    a_call_bytes: assert property (callGo |-> ##2 memWe [*2] ##1 !memWe)
        else $error("call byte count wrong");
    a_irq_prio: assert property (irqGo |-> ##7
        {condFlags[5], condFlags[3]} == $past(irqPrio, 7))
        else $error("priority pair not loaded");
    a_pcl_first: assert property (irqGo |-> ##2
        memWe && memWrData == programCounter[7:0])
        else $error("first stacked byte not pc low");
    a_y_kept: assert property (irqGo |=> $stable(indexY) [*7])
        else $error("second index touched by irq");
endmodule
bind cpu_core_register_set cpu_core_register_set_props i_props (.*);

// >>> tb/tb_cpu_core_register_set.sv
// self-checking bench for the processor core register set
`timescale 1ns/1ns
module tb_cpu_core_register_set;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cmdValid = 1'h0;
    logic cmdReady;
    cpu_core_register_set_pkg::cmd_e cmd;
    cpu_core_register_set_pkg::alu_e aluOp;
    cpu_core_register_set_pkg::reg_e regSel;
    logic [7:0] operand = 8'h00;
    logic [15:0] target = 16'h0000;
    logic [1:0] irqPrio = 2'h0;
    logic [7:0] accum, indexX, indexY, condFlags, memWrData, memRdData;
    logic [15:0] programCounter, stackPointer, memAddr;
    logic memWe, memRe;
    logic [7:0] ctx [5] = '{8'hC3, 8'hA5, 8'hAA, 8'h80, 8'hE4};
    int failures = 0;
    int n_tests = 0;
    cpu_core_register_set i_dut (.*);
    cpu_stack_mem i_mem (.*);
    always #4 clk = ~clk;
    // ========
    // tasks
    task automatic op(input cpu_core_register_set_pkg::cmd_e c,
            input logic [7:0] d = 8'h00, input logic [1:0] r = 2'h0);
        int n;
        cmd <= c;
        operand <= d;
        regSel <= cpu_core_register_set_pkg::reg_e'(r);
        cmdValid <= 1'h1;
        n = 0;
        do @(posedge clk); while (cmdReady !== 1'h1 && ++n < 50);
        cmdValid <= 1'h0;
        @(posedge clk);
        while (cmdReady !== 1'h1 && ++n < 50) @(posedge clk);
    endtask
    task automatic chk(input string s, input logic [15:0] e, g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        conclude();
    end
    // ========
    // tests
    initial begin
        cmd = cpu_core_register_set_pkg::CMD_NOP;
        aluOp = cpu_core_register_set_pkg::ALU_ADD;
        regSel = cpu_core_register_set_pkg::REG_ACC;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk("sp", 16'h01FF, stackPointer);
        chk("acc_flags", 16'h00E8, {accum, condFlags});
        op(cpu_core_register_set_pkg::CMD_LOAD, 8'h0F);
        op(cpu_core_register_set_pkg::CMD_ALU, 8'h01);
        chk("acc_flags", 16'h10F8, {accum, condFlags});
        op(cpu_core_register_set_pkg::CMD_ALU, 8'hF0);
        chk("acc_flags", 16'h00EB, {accum, condFlags});
        op(cpu_core_register_set_pkg::CMD_ALU, 8'h80);
        chk("acc_flags", 16'h80EC, {accum, condFlags});
        aluOp <= cpu_core_register_set_pkg::ALU_SUB;
        op(cpu_core_register_set_pkg::CMD_ALU, 8'h81);
        chk("acc_flags", 16'hFFED, {accum, condFlags});
        aluOp <= cpu_core_register_set_pkg::ALU_AND;
        op(cpu_core_register_set_pkg::CMD_ALU, 8'h80);
        chk("acc_flags", 16'h80ED, {accum, condFlags});
        op(cpu_core_register_set_pkg::CMD_RESET_CARRY);
        op(cpu_core_register_set_pkg::CMD_SET_CARRY);
        chk("acc_flags", 16'h80ED, {accum, condFlags});
        op(cpu_core_register_set_pkg::CMD_RESET_CARRY);
        chk("acc_flags", 16'h80EC, {accum, condFlags});
        $display("test alu done");
        op(cpu_core_register_set_pkg::CMD_PREFIX_Y);
        op(cpu_core_register_set_pkg::CMD_LOAD, 8'h55, 2'h1);
        op(cpu_core_register_set_pkg::CMD_LOAD, 8'hAA, 2'h1);
        chk("index", 16'hAA55, {indexX, indexY});
        op(cpu_core_register_set_pkg::CMD_IRQ_ENABLE);
        chk("acc_flags", 16'h80E4, {accum, condFlags});
        $display("test index done");
        target <= 16'hA5C3;
        op(cpu_core_register_set_pkg::CMD_JUMP);
        target <= 16'h1234;
        irqPrio <= 2'h1;
        op(cpu_core_register_set_pkg::CMD_IRQ_ENTRY);
        chk("pc", 16'h1234, programCounter);
        chk("acc_flags", 16'h80CC, {accum, condFlags});
        chk("sp", 16'h01FA, stackPointer);
        for (int i = 0; i < 5; i++) begin
            chk("stack", {8'h00, ctx[i]}, {8'h00, i_mem.mem[8'hFF - i]});
        end
        op(cpu_core_register_set_pkg::CMD_IRQ_RETURN);
        chk("pc", 16'hA5C3, programCounter);
        chk("acc_flags", 16'h80E4, {accum, condFlags});
        chk("index", 16'hAA55, {indexX, indexY});
        $display("test irq done");
        op(cpu_core_register_set_pkg::CMD_CALL);
        chk("sp", 16'h01FD, stackPointer);
        op(cpu_core_register_set_pkg::CMD_RETURN);
        chk("pc", 16'hA5C3, programCounter);
        op(cpu_core_register_set_pkg::CMD_STACK_LOW_WR, 8'h00);
        chk("sp", 16'h0100, stackPointer);
        op(cpu_core_register_set_pkg::CMD_PUSH);
        chk("sp", 16'h01FF, stackPointer);
        op(cpu_core_register_set_pkg::CMD_POP, 8'h00, 2'h1);
        chk("index", 16'h8055, {indexX, indexY});
        op(cpu_core_register_set_pkg::CMD_STACK_RESET);
        chk("sp", 16'h01FF, stackPointer);
        $display("test stack done");
        conclude();
    end
endmodule
